// File: rtl/swd_pkg.sv
//==========================================================================
// Contract
// - soft_trap bumps PC, pushes PC low, PC high, X, A, flags; SP falls each push
// - soft_trap then sets I, loads PC from vector high then low; nine cycles
// - wait clears I, halts until interrupt or wake pulse, one cycle, other flags kept
// - zero_neg_check tests A, X or memory against zero, storing nothing
// - zero_neg_check clears V, sets N and Z; 3D three, 4D one, 9E6D four cycles
// - stack_offset_byte_mode address is SP plus one offset byte
// - stack_offset_word_mode address is SP plus a two-byte offset
// - extended_mode address comes from two bytes, high byte first
// - idx_off16_mode adds a two-byte offset, high first, to H:X
// - idx_off8_postinc_mode adds one byte to H:X, then bumps H:X
// - compare-and-branch direct fetches address and signed branch offset, then reads direct address
// - imm_to_direct_move writes an immediate byte to a direct address
// - postinc_to_direct_move reads at H:X, bumps H:X, writes direct address
// - direct_to_postinc_move reads direct address, writes at H:X, then bumps H:X
//==========================================================================
package swd_pkg;

	// opcodes
	localparam logic [7:0] OP_SOFT_TRAP = 8'h83;
	localparam logic [7:0] OP_WAIT      = 8'h8f;
	localparam logic [7:0] OP_PREFIX    = 8'h9e;
	localparam logic [7:0] OP_ZNC_DIR   = 8'h3d;
	localparam logic [7:0] OP_ZNC_A     = 8'h4d;
	localparam logic [7:0] OP_ZNC_X     = 8'h5d;
	localparam logic [7:0] OP_ZNC_IX1   = 8'h6d;
	localparam logic [7:0] OP_ZNC_IX    = 8'h7d;
	localparam logic [7:0] OP_ZNC_SPB   = 8'h6d;
	localparam logic [7:0] OP_LDA_LONG  = 8'hc6;
	localparam logic [7:0] OP_LDA_IDXW  = 8'hd6;
	localparam logic [7:0] OP_LDA_SPW   = 8'hd6;
	localparam logic [7:0] OP_CBR_DIR   = 8'h31;
	localparam logic [7:0] OP_CBR_IXP   = 8'h61;
	localparam logic [7:0] OP_MOV_IDIR  = 8'h6e;
	localparam logic [7:0] OP_MOV_PD    = 8'h7e;
	localparam logic [7:0] OP_MOV_DP    = 8'h5e;
	localparam logic [7:0] OP_A2F       = 8'h84;
	localparam logic [7:0] OP_F2A       = 8'h85;
	localparam logic [7:0] OP_A2X       = 8'h97;
	localparam logic [7:0] OP_X2A       = 8'h9f;
	localparam logic [7:0] OP_S2P       = 8'h95;
	localparam logic [7:0] OP_P2S       = 8'h94;

	// flag register layout: V 1 1 H I N Z C
	localparam int         FB_V     = 7;
	localparam int         FB_I     = 3;
	localparam int         FB_N     = 2;
	localparam int         FB_Z     = 1;
	localparam logic [7:0] FLG_ONES = 8'h60;

	// reset values and vectors
	localparam logic [7:0]  RST_FLAGS = 8'h68;
	localparam logic [15:0] RST_SP    = 16'h00ff;
	localparam logic [15:0] RST_PC    = 16'h0000;
	localparam logic [15:0] VEC_HI    = 16'hfffc;
	localparam logic [15:0] VEC_LO    = 16'hfffd;
	localparam logic [2:0]  PUSH_LAST = 3'h4;

	// register bus byte offsets and fields
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam logic [3:0] REG_CORE = 4'h8;
	localparam logic [3:0] REG_PTR  = 4'hc;
	localparam int         CTRL_RUN  = 0;
	localparam int         CTRL_WAKE = 1;

	typedef enum logic [3:0] {
		st_fetch   = 4'h0,
		st_pre     = 4'h1,
		st_op1     = 4'h3,
		st_op2     = 4'h2,
		st_mem     = 4'h6,
		st_wr      = 4'h7,
		st_idle    = 4'h5,
		st_push    = 4'h4,
		st_vech    = 4'hc,
		st_vecl    = 4'hd,
		st_waiting = 4'hf
	} swd_state_t;

	typedef enum logic [3:0] {
		inherent_mode, direct_mode, extended_mode, idx_mode, idx_off8_mode,
		idx_off16_mode, stack_offset_byte_mode, stack_offset_word_mode,
		idx_off8_postinc_mode, direct_rel_mode, imm_to_direct_move,
		postinc_to_direct_move, direct_to_postinc_move
	} swd_mode_t;

	typedef enum logic [3:0] {
		k_none, k_zero_neg_check, k_load, k_cmp_branch, k_move, k_soft_trap,
		k_acc_to_flags, k_stackptr_to_pair, k_pair_to_stackptr
	} swd_kind_t;

endpackage : swd_pkg

// File: rtl/swd_ea.sv
`timescale 1ns/1ps

module swd_ea (
	input  wire swd_pkg::swd_mode_t i_mode,
	input  wire logic [7:0]         i_b1,
	input  wire logic [7:0]         i_b2,
	input  wire logic [15:0]        i_sp,
	input  wire logic [15:0]        i_hx,
	output logic      [15:0]        o_ea
);

	//==========================================================================
	// operand address of the read cycle
	always_comb
	begin
		case (i_mode)
			swd_pkg::direct_mode,
			swd_pkg::direct_rel_mode,
			swd_pkg::direct_to_postinc_move:  o_ea = {8'h00, i_b1};
			swd_pkg::extended_mode:           o_ea = {i_b1, i_b2};
			swd_pkg::idx_off16_mode:          o_ea = i_hx + {i_b1, i_b2};
			swd_pkg::idx_off8_mode,
			swd_pkg::idx_off8_postinc_mode:   o_ea = i_hx + {8'h00, i_b1};
			swd_pkg::stack_offset_byte_mode:  o_ea = i_sp + {8'h00, i_b1};
			swd_pkg::stack_offset_word_mode:  o_ea = i_sp + {i_b1, i_b2};
			default:                          o_ea = i_hx;
		endcase
	end

endmodule : swd_ea

// File: rtl/swd_core.sv
`timescale 1ns/1ps

module swd_core (
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic [3:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	output logic      [15:0] o_mem_addr,
	output logic             o_mem_rd,
	output logic             o_mem_wr,
	output logic      [7:0]  o_mem_wdata,
	input  wire logic [7:0]  i_mem_rdata,
	input  wire logic        i_irq,
	output logic             o_waiting
);

	//==========================================================================
	// state
	swd_pkg::swd_state_t state_ff, nxt_state;
	swd_pkg::swd_mode_t  mode_ff, nxt_mode;
	swd_pkg::swd_kind_t  kind_ff, nxt_kind;
	logic [7:0]          b1_ff, nxt_b1;
	logic [7:0]          b2_ff, nxt_b2;
	logic [7:0]          dat_ff, nxt_dat;
	logic [2:0]          cnt_ff, nxt_cnt;
	logic [15:0]         pc_ff, nxt_pc;
	logic [15:0]         sp_ff, nxt_sp;
	logic [7:0]          a_ff, nxt_a;
	logic [7:0]          x_ff, nxt_x;
	logic [7:0]          h_ff, nxt_h;
	logic [7:0]          flag_register_ff, nxt_flg;
	logic [15:0]         addr_ff, nxt_addr;
	logic                rd_ff, nxt_rd;
	logic                wr_ff, nxt_wr;
	logic [7:0]          wdata_ff, nxt_wdata;
	logic [15:0]         ea;
	logic [15:0]         hx_inc;
	logic                take;
	logic                run_ff;
	logic                wake_ff;
	logic                wreq_ff;
	logic [31:0]         rdata_ff, nxt_rdata;
	logic                waiting_ff;
	logic                bus_req;
	logic                bus_wr_go;

	assign take   = (state_ff == swd_pkg::st_fetch) && run_ff;
	assign hx_inc = {h_ff, x_ff} + 16'h0001;

	function automatic logic [7:0] nz_flags(input logic [7:0] f, input logic [7:0] v);
		logic [7:0] r;
		r = f;
		r[swd_pkg::FB_V] = 1'b0;
		r[swd_pkg::FB_N] = v[7];
		r[swd_pkg::FB_Z] = (v == 8'h00);
		return r;
	endfunction : nz_flags

	//==========================================================================
	// sequencer: one bus cycle per state, none in st_idle or st_waiting
	always_comb
	begin
		nxt_state = state_ff;
		nxt_mode  = mode_ff;
		nxt_kind  = kind_ff;
		nxt_b1    = b1_ff;
		nxt_b2    = b2_ff;
		nxt_dat   = dat_ff;
		nxt_cnt   = cnt_ff;
		nxt_pc    = pc_ff;
		nxt_sp    = sp_ff;
		nxt_a     = a_ff;
		nxt_x     = x_ff;
		nxt_h     = h_ff;
		nxt_flg   = flag_register_ff;
		case (state_ff)
			swd_pkg::st_fetch:
				if (run_ff)
				begin
					nxt_pc   = pc_ff + 16'h0001;
					nxt_mode = swd_pkg::inherent_mode;
					nxt_kind = swd_pkg::k_none;
					nxt_state = swd_pkg::st_op1;
					case (i_mem_rdata)
						swd_pkg::OP_PREFIX:
							nxt_state = swd_pkg::st_pre;
						swd_pkg::OP_SOFT_TRAP:
						begin
							nxt_kind  = swd_pkg::k_soft_trap;
							nxt_state = swd_pkg::st_idle;
						end
						swd_pkg::OP_WAIT:
						begin
							nxt_flg[swd_pkg::FB_I] = 1'b0;
							nxt_state = swd_pkg::st_waiting;
						end
						swd_pkg::OP_ZNC_A:
						begin
							nxt_flg   = nz_flags(flag_register_ff, a_ff);
							nxt_state = swd_pkg::st_fetch;
						end
						swd_pkg::OP_ZNC_X:
						begin
							nxt_flg   = nz_flags(flag_register_ff, x_ff);
							nxt_state = swd_pkg::st_fetch;
						end
						swd_pkg::OP_ZNC_DIR:
						begin
							nxt_kind = swd_pkg::k_zero_neg_check;
							nxt_mode = swd_pkg::direct_mode;
						end
						swd_pkg::OP_ZNC_IX1:
						begin
							nxt_kind = swd_pkg::k_zero_neg_check;
							nxt_mode = swd_pkg::idx_off8_mode;
						end
						swd_pkg::OP_ZNC_IX:
						begin
							nxt_kind  = swd_pkg::k_zero_neg_check;
							nxt_mode  = swd_pkg::idx_mode;
							nxt_state = swd_pkg::st_mem;
						end
						swd_pkg::OP_LDA_LONG:
						begin
							nxt_kind = swd_pkg::k_load;
							nxt_mode = swd_pkg::extended_mode;
						end
						swd_pkg::OP_LDA_IDXW:
						begin
							nxt_kind = swd_pkg::k_load;
							nxt_mode = swd_pkg::idx_off16_mode;
						end
						swd_pkg::OP_CBR_DIR:
						begin
							nxt_kind = swd_pkg::k_cmp_branch;
							nxt_mode = swd_pkg::direct_rel_mode;
						end
						swd_pkg::OP_CBR_IXP:
						begin
							nxt_kind = swd_pkg::k_cmp_branch;
							nxt_mode = swd_pkg::idx_off8_postinc_mode;
						end
						swd_pkg::OP_MOV_IDIR:
						begin
							nxt_kind = swd_pkg::k_move;
							nxt_mode = swd_pkg::imm_to_direct_move;
						end
						swd_pkg::OP_MOV_PD:
						begin
							nxt_kind = swd_pkg::k_move;
							nxt_mode = swd_pkg::postinc_to_direct_move;
						end
						swd_pkg::OP_MOV_DP:
						begin
							nxt_kind = swd_pkg::k_move;
							nxt_mode = swd_pkg::direct_to_postinc_move;
						end
						swd_pkg::OP_A2F:
						begin
							nxt_kind  = swd_pkg::k_acc_to_flags;
							nxt_state = swd_pkg::st_idle;
						end
						swd_pkg::OP_S2P:
						begin
							nxt_kind  = swd_pkg::k_stackptr_to_pair;
							nxt_state = swd_pkg::st_idle;
						end
						swd_pkg::OP_P2S:
						begin
							nxt_kind  = swd_pkg::k_pair_to_stackptr;
							nxt_state = swd_pkg::st_idle;
						end
						swd_pkg::OP_F2A:
						begin
							nxt_a     = flag_register_ff;
							nxt_state = swd_pkg::st_fetch;
						end
						swd_pkg::OP_A2X:
						begin
							nxt_x     = a_ff;
							nxt_state = swd_pkg::st_fetch;
						end
						swd_pkg::OP_X2A:
						begin
							nxt_a     = x_ff;
							nxt_state = swd_pkg::st_fetch;
						end
						// opcodes outside this group pass as one-cycle no-ops
						default:
							nxt_state = swd_pkg::st_fetch;
					endcase
				end
			swd_pkg::st_pre:
			begin
				nxt_pc    = pc_ff + 16'h0001;
				nxt_state = swd_pkg::st_op1;
				case (i_mem_rdata)
					swd_pkg::OP_ZNC_SPB:
					begin
						nxt_kind = swd_pkg::k_zero_neg_check;
						nxt_mode = swd_pkg::stack_offset_byte_mode;
					end
					swd_pkg::OP_LDA_SPW:
					begin
						nxt_kind = swd_pkg::k_load;
						nxt_mode = swd_pkg::stack_offset_word_mode;
					end
					default:
						nxt_state = swd_pkg::st_fetch;
				endcase
			end
			swd_pkg::st_op1:
			begin
				nxt_b1 = i_mem_rdata;
				nxt_pc = pc_ff + 16'h0001;
				case (mode_ff)
					swd_pkg::extended_mode,
					swd_pkg::idx_off16_mode,
					swd_pkg::stack_offset_word_mode,
					swd_pkg::direct_rel_mode,
					swd_pkg::idx_off8_postinc_mode,
					swd_pkg::imm_to_direct_move:  nxt_state = swd_pkg::st_op2;
					default:                      nxt_state = swd_pkg::st_mem;
				endcase
			end
			swd_pkg::st_op2:
			begin
				nxt_b2 = i_mem_rdata;
				nxt_pc = pc_ff + 16'h0001;
				nxt_state = swd_pkg::st_mem;
				if (mode_ff == swd_pkg::imm_to_direct_move)
				begin
					nxt_dat   = b1_ff;
					nxt_flg   = nz_flags(flag_register_ff, b1_ff);
					nxt_state = swd_pkg::st_wr;
				end
			end
			swd_pkg::st_mem:
			begin
				nxt_dat   = i_mem_rdata;
				nxt_state = swd_pkg::st_fetch;
				case (kind_ff)
					swd_pkg::k_zero_neg_check:
						nxt_flg = nz_flags(flag_register_ff, i_mem_rdata);
					swd_pkg::k_load:
					begin
						nxt_a   = i_mem_rdata;
						nxt_flg = nz_flags(flag_register_ff, i_mem_rdata);
					end
					swd_pkg::k_cmp_branch:
					begin
						if (i_mem_rdata == a_ff)
							nxt_pc = pc_ff + {{8{b2_ff[7]}}, b2_ff};
						if (mode_ff == swd_pkg::idx_off8_postinc_mode)
							{nxt_h, nxt_x} = hx_inc;
						nxt_state = swd_pkg::st_idle;
					end
					swd_pkg::k_move:
					begin
						nxt_flg = nz_flags(flag_register_ff, i_mem_rdata);
						if (mode_ff == swd_pkg::postinc_to_direct_move)
							{nxt_h, nxt_x} = hx_inc;
						nxt_state = swd_pkg::st_wr;
					end
					default:
						nxt_state = swd_pkg::st_fetch;
				endcase
			end
			swd_pkg::st_wr:
			begin
				if (mode_ff == swd_pkg::direct_to_postinc_move)
					{nxt_h, nxt_x} = hx_inc;
				nxt_state = swd_pkg::st_fetch;
			end
			swd_pkg::st_idle:
			begin
				nxt_state = swd_pkg::st_fetch;
				case (kind_ff)
					swd_pkg::k_soft_trap:
					begin
						nxt_cnt   = 3'h0;
						nxt_state = swd_pkg::st_push;
					end
					swd_pkg::k_acc_to_flags:
						nxt_flg = a_ff | swd_pkg::FLG_ONES;
					swd_pkg::k_stackptr_to_pair:
						{nxt_h, nxt_x} = sp_ff + 16'h0001;
					swd_pkg::k_pair_to_stackptr:
						nxt_sp = {h_ff, x_ff} - 16'h0001;
					default:
						nxt_state = swd_pkg::st_fetch;
				endcase
			end
			swd_pkg::st_push:
			begin
				nxt_sp  = sp_ff - 16'h0001;
				nxt_cnt = cnt_ff + 3'h1;
				if (cnt_ff == swd_pkg::PUSH_LAST)
				begin
					nxt_flg[swd_pkg::FB_I] = 1'b1;
					nxt_state = swd_pkg::st_vech;
				end
			end
			swd_pkg::st_vech:
			begin
				nxt_pc[15:8] = i_mem_rdata;
				nxt_state    = swd_pkg::st_vecl;
			end
			swd_pkg::st_vecl:
			begin
				nxt_pc[7:0] = i_mem_rdata;
				nxt_state   = swd_pkg::st_fetch;
			end
			swd_pkg::st_waiting:
				// no fetches while parked; i_irq or a wake pulse resumes fetching at the next opcode, with no vectoring
				if (i_irq || wake_ff)
					nxt_state = swd_pkg::st_fetch;
			default:
				nxt_state = swd_pkg::st_fetch;
		endcase
	end

	swd_ea u_ea (
		.i_mode (nxt_mode),
		.i_b1   (nxt_b1),
		.i_b2   (nxt_b2),
		.i_sp   (nxt_sp),
		.i_hx   ({nxt_h, nxt_x}),
		.o_ea   (ea)
	);

	//==========================================================================
	// bus cycle for the next state, registered so the pins come from flops
	always_comb
	begin
		nxt_addr  = nxt_pc;
		nxt_rd    = 1'b0;
		nxt_wr    = 1'b0;
		nxt_wdata = wdata_ff;
		case (nxt_state)
			swd_pkg::st_fetch,
			swd_pkg::st_pre,
			swd_pkg::st_op1,
			swd_pkg::st_op2:
				nxt_rd = 1'b1;
			swd_pkg::st_mem:
			begin
				nxt_addr = ea;
				nxt_rd   = 1'b1;
			end
			swd_pkg::st_wr:
			begin
				nxt_wr    = 1'b1;
				nxt_wdata = nxt_dat;
				case (nxt_mode)
					swd_pkg::imm_to_direct_move:      nxt_addr = {8'h00, nxt_b2};
					swd_pkg::postinc_to_direct_move:  nxt_addr = {8'h00, nxt_b1};
					default:                          nxt_addr = {nxt_h, nxt_x};
				endcase
			end
			swd_pkg::st_push:
			begin
				nxt_addr = nxt_sp;
				nxt_wr   = 1'b1;
				case (nxt_cnt)
					3'h0:    nxt_wdata = nxt_pc[7:0];
					3'h1:    nxt_wdata = nxt_pc[15:8];
					3'h2:    nxt_wdata = nxt_x;
					3'h3:    nxt_wdata = nxt_a;
					default: nxt_wdata = nxt_flg;
				endcase
			end
			swd_pkg::st_vech:
			begin
				nxt_addr = swd_pkg::VEC_HI;
				nxt_rd   = 1'b1;
			end
			swd_pkg::st_vecl:
			begin
				nxt_addr = swd_pkg::VEC_LO;
				nxt_rd   = 1'b1;
			end
			default:
				nxt_rd = 1'b0;
		endcase
	end

	//==========================================================================
	// sequencer registers
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			state_ff <= swd_pkg::st_fetch;
			mode_ff  <= swd_pkg::inherent_mode;
			kind_ff  <= swd_pkg::k_none;
			b1_ff    <= 8'h00;
			b2_ff    <= 8'h00;
			dat_ff   <= 8'h00;
			cnt_ff   <= 3'h0;
		end
		else
		begin
			state_ff <= nxt_state;
			mode_ff  <= nxt_mode;
			kind_ff  <= nxt_kind;
			b1_ff    <= nxt_b1;
			b2_ff    <= nxt_b2;
			dat_ff   <= nxt_dat;
			cnt_ff   <= nxt_cnt;
		end
	end

	//==========================================================================
	// programmer-visible registers
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			pc_ff            <= swd_pkg::RST_PC;
			sp_ff            <= swd_pkg::RST_SP;
			a_ff             <= 8'h00;
			x_ff             <= 8'h00;
			h_ff             <= 8'h00;
			flag_register_ff <= swd_pkg::RST_FLAGS;
		end
		else
		begin
			pc_ff            <= nxt_pc;
			sp_ff            <= nxt_sp;
			a_ff             <= nxt_a;
			x_ff             <= nxt_x;
			h_ff             <= nxt_h;
			flag_register_ff <= nxt_flg;
		end
	end

	//==========================================================================
	// memory port
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			addr_ff    <= swd_pkg::RST_PC;
			rd_ff      <= 1'b0;
			wr_ff      <= 1'b0;
			wdata_ff   <= 8'h00;
			waiting_ff <= 1'b0;
		end
		else
		begin
			addr_ff    <= nxt_addr;
			rd_ff      <= nxt_rd;
			wr_ff      <= nxt_wr;
			wdata_ff   <= nxt_wdata;
			waiting_ff <= (nxt_state == swd_pkg::st_waiting);
		end
	end

	//==========================================================================
	// register bus slave: one wait state on every access
	assign bus_req   = i_avs_read || i_avs_write;
	assign bus_wr_go = i_avs_write && !wreq_ff;

	always_comb
	begin
		case (i_avs_address)
			swd_pkg::REG_CTRL:  nxt_rdata = {30'h0, wake_ff, run_ff};
			swd_pkg::REG_STAT:  nxt_rdata = {24'h0, state_ff, 3'h0, waiting_ff};
			swd_pkg::REG_CORE:  nxt_rdata = {flag_register_ff, a_ff, h_ff, x_ff};
			swd_pkg::REG_PTR:   nxt_rdata = {pc_ff, sp_ff};
			default:            nxt_rdata = 32'h0;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			wreq_ff  <= 1'b1;
			rdata_ff <= 32'h0;
		end
		else
		begin
			wreq_ff <= !(bus_req && wreq_ff);
			if (i_avs_read && wreq_ff)
				rdata_ff <= nxt_rdata;
		end
	end

	// wake is a write-one pulse; it lasts one cycle so a late write cannot release a later wait
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			run_ff  <= 1'b0;
			wake_ff <= 1'b0;
		end
		else
		begin
			wake_ff <= bus_wr_go && (i_avs_address == swd_pkg::REG_CTRL)
				&& i_avs_writedata[swd_pkg::CTRL_WAKE];
			if (bus_wr_go && (i_avs_address == swd_pkg::REG_CTRL))
				run_ff <= i_avs_writedata[swd_pkg::CTRL_RUN];
		end
	end

	assign o_avs_readdata    = rdata_ff;
	assign o_avs_waitrequest = wreq_ff;
	assign o_mem_addr        = addr_ff;
	assign o_mem_rd          = rd_ff;
	assign o_mem_wr          = wr_ff;
	assign o_mem_wdata       = wdata_ff;
	assign o_waiting         = waiting_ff;

	//==========================================================================
	// checks
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);

	sequence trap_go;
		take && (i_mem_rdata == swd_pkg::OP_SOFT_TRAP);
	endsequence
	sequence trap_body;
		(state_ff == swd_pkg::st_idle) ##1 (state_ff == swd_pkg::st_push) [*5]
		##1 (state_ff == swd_pkg::st_vech) ##1 (state_ff == swd_pkg::st_vecl) ##1 (state_ff == swd_pkg::st_fetch);
	endsequence

	chk_trap_length: assert property (trap_go |=> trap_body)
		else $error("soft trap did not take nine cycles");
	chk_trap_push: assert property ((state_ff == swd_pkg::st_push) |-> o_mem_wr && (o_mem_addr == sp_ff))
		else $error("push not written at stack pointer");
	chk_trap_spdec: assert property ((state_ff == swd_pkg::st_push) |=> sp_ff == $past(sp_ff) - 16'h0001)
		else $error("stack pointer not decremented after push");
	chk_trap_order: assert property ((state_ff == swd_pkg::st_idle && kind_ff == swd_pkg::k_soft_trap)
		|=> (o_mem_wdata == pc_ff[7:0]) ##1 (o_mem_wdata == pc_ff[15:8]))
		else $error("program counter pushed in wrong order");
	chk_trap_mask: assert property ((state_ff == swd_pkg::st_vech) |-> flag_register_ff[swd_pkg::FB_I])
		else $error("mask not set before vector fetch");
	chk_wait_mask: assert property (take && (i_mem_rdata == swd_pkg::OP_WAIT)
		|=> (state_ff == swd_pkg::st_waiting) && !flag_register_ff[swd_pkg::FB_I]
		&& (flag_register_ff[7:4] == $past(flag_register_ff[7:4]))
		&& (flag_register_ff[2:0] == $past(flag_register_ff[2:0])))
		else $error("wait did not clear mask or park");
	chk_test_flags: assert property (take && (i_mem_rdata == swd_pkg::OP_ZNC_A)
		|=> !flag_register_ff[swd_pkg::FB_V] && (flag_register_ff[swd_pkg::FB_Z] == ($past(a_ff) == 8'h00))
		&& (a_ff == $past(a_ff)) && (state_ff == swd_pkg::st_fetch))
		else $error("accumulator test flags wrong");
	chk_pair_load: assert property (take && (i_mem_rdata == swd_pkg::OP_S2P)
		|=> (state_ff == swd_pkg::st_idle) ##1 ({h_ff, x_ff} == $past(sp_ff, 2) + 16'h0001)
		&& (state_ff == swd_pkg::st_fetch))
		else $error("pair not loaded with stack pointer plus one");
	chk_xfer_flags: assert property (take && (i_mem_rdata == swd_pkg::OP_A2X || i_mem_rdata == swd_pkg::OP_X2A)
		|=> (flag_register_ff == $past(flag_register_ff)) && (state_ff == swd_pkg::st_fetch))
		else $error("index transfer changed flags or took too long");
	chk_acc_flag_load: assert property (take && (i_mem_rdata == swd_pkg::OP_A2F)
		|=> ##1 (flag_register_ff == ($past(a_ff, 2) | swd_pkg::FLG_ONES)))
		else $error("flags not loaded from accumulator in two cycles");

endmodule : swd_core

// File: test/swd_mem_model.sv
`timescale 1ns/1ps

//==========================================================================
// zero-latency program and stack memory
module swd_mem_model (
	input  wire logic        i_clk,
	input  wire logic [15:0] i_addr,
	input  wire logic        i_rd,
	input  wire logic        i_wr,
	input  wire logic [7:0]  i_wdata,
	output logic      [7:0]  o_rdata
);
	logic [7:0] mem [0:65535];

	// off-read cycles show inverted data so a stale sample is caught
	assign o_rdata = i_rd ? mem[i_addr] : ~mem[i_addr];

	initial
	begin
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'h9d;
	end

	always @(posedge i_clk)
	begin
		if (i_wr)
			mem[i_addr] <= i_wdata;
	end
endmodule : swd_mem_model

// File: test/swd_core_test.sv
`timescale 1ns/1ps

//==========================================================================
// bench
module swd_core_test;
	logic        i_clk, i_nrst, i_avs_read, i_avs_write, i_irq, o_avs_waitrequest;
	logic        o_mem_rd, o_mem_wr, o_waiting;
	logic [3:0]  i_avs_address;
	logic [31:0] i_avs_writedata, o_avs_readdata, q;
	logic [15:0] o_mem_addr;
	logic [7:0]  o_mem_wdata, i_mem_rdata, r, fl;
	logic [7:0]  prog [0:7];
	logic [7:0]  prog2 [0:31];
	int          err_total, checked, seed;

	swd_core u_swd_core (.i_clk(i_clk), .i_nrst(i_nrst), .i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
		.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
		.o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
		.o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata), .i_irq(i_irq), .o_waiting(o_waiting));

	swd_mem_model u_swd_mem_model (.i_clk(i_clk), .i_addr(o_mem_addr), .i_rd(o_mem_rd),
		.i_wr(o_mem_wr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));

	task close_out;
		if (err_total == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// flags after a zero/negative test of v: overflow cleared, N and Z set from v, other bits kept
	function automatic logic [7:0] tested(input logic [7:0] f, input logic [7:0] v);
		return {1'b0, f[6:3], v[7], (v == 8'h00), f[0]};
	endfunction : tested

	// holds the request until waitrequest is sampled low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_avs_read      <= !w;
		i_avs_write     <= w;
		i_avs_address   <= a;
		i_avs_writedata <= d;
		do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
		q = o_avs_readdata;
		i_avs_read  <= 1'b0;
		i_avs_write <= 1'b0;
	endtask : bus

	initial
	begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	initial
	begin
		#100000;
		err_total++;
		close_out;
	end

	initial
	begin
		{i_nrst, i_avs_read, i_avs_write, i_irq, i_avs_address, i_avs_writedata} <= '0;
		err_total = 0;
		checked = 0;
		seed = 302;
		repeat (2) @(posedge i_clk);
		i_nrst <= 1'b1;
		@(negedge i_clk);
		chk(o_avs_waitrequest, 1'b1);
		r = 8'($random(seed));
		r[0] = 1'b1;
		// bit 2 clear keeps r apart from the 9d fill, so the indexed compare misses
		r[2] = 1'b0;
		fl = tested(8'h68, r);
		prog = '{8'h6e, r, 8'h40, 8'hc6, 8'h00, 8'h40, 8'h97, 8'h83};
		for (int i = 0; i < 8; i++)
			u_swd_mem_model.mem[i] = prog[i];
		u_swd_mem_model.mem[16'hfffc] = 8'h00;
		u_swd_mem_model.mem[16'hfffd] = 8'h20;
		u_swd_mem_model.mem[16'h0020] = 8'h8f;
		u_swd_mem_model.mem[16'h0021] = 8'h85;
		u_swd_mem_model.mem[16'h0022] = 8'h4d;
		bus(1'b1, 4'h0, 32'h1);
		for (int i = 0; i < 200 && o_waiting !== 1'b1; i++)
			@(posedge i_clk);
		chk(o_waiting, 1'b1);
		bus(1'b0, 4'h8, 32'h0);
		chk(q, {fl & 8'hf7, r, 8'h00, r});
		bus(1'b0, 4'hc, 32'h0);
		chk(q, 32'h002100fa);
		chk(u_swd_mem_model.mem[16'h00ff], 8'h08);
		chk(u_swd_mem_model.mem[16'h00fe], 8'h00);
		chk({u_swd_mem_model.mem[16'h00fd], u_swd_mem_model.mem[16'h00fc]}, {r, r});
		chk(u_swd_mem_model.mem[16'h00fb], fl);
		chk(u_swd_mem_model.mem[16'h0040], r);
		i_irq <= 1'b1;
		for (int i = 0; i < 20 && o_waiting !== 1'b0; i++)
			@(posedge i_clk);
		i_irq <= 1'b0;
		repeat (10) @(posedge i_clk);
		bus(1'b1, 4'h0, 32'h0);
		bus(1'b0, 4'h8, 32'h0);
		chk(q, {8'h60, fl & 8'hf7, 8'h00, r});
		bus(1'b0, 4'h1, 32'h0);
		chk(q, 32'h0);
		// second program after a mid-run reset: moves, offsets, branch, transfers, tests
		@(posedge i_clk);
		i_nrst <= 1'b0;
		prog2 = '{8'h95, 8'h5e, 8'h40, 8'h7e, 8'h40, 8'h9e, 8'hd6, 8'h00, 8'h01, 8'h31, 8'hfc,
			8'h01, 8'h97, 8'h61, 8'hfe, 8'h00, 8'hd6, 8'h00, 8'hfd, 8'h84, 8'h94, 8'h9e,
			8'h6d, 8'hfe, 8'h6d, 8'hfd, 8'h7d, 8'h5d, 8'h9f, 8'h3d, 8'hfd, 8'h8f};
		for (int i = 0; i < 32; i++)
			u_swd_mem_model.mem[i] = prog2[i];
		repeat (2) @(posedge i_clk);
		i_nrst <= 1'b1;
		bus(1'b1, 4'h0, 32'h1);
		for (int i = 0; i < 300 && o_waiting !== 1'b1; i++)
			@(posedge i_clk);
		chk(o_waiting, 1'b1);
		bus(1'b0, 4'h8, 32'h0);
		chk(q, {tested(8'hfd, r) & 8'hf7, 8'h03, 8'h01, 8'h03});
		bus(1'b0, 4'hc, 32'h0);
		chk(q, 32'h00200102);
		bus(1'b0, 4'h4, 32'h0);
		chk(q, 32'h000000f1);
		chk(u_swd_mem_model.mem[16'h0100], r);
		chk(u_swd_mem_model.mem[16'h0040], 8'h9d);
		bus(1'b1, 4'h0, 32'h3);
		for (int i = 0; i < 20 && o_waiting !== 1'b0; i++)
			@(posedge i_clk);
		chk(o_waiting, 1'b0);
		for (int i = 0; i < 20 && o_waiting !== 1'b1; i++)
			@(posedge i_clk);
		chk(o_waiting, 1'b1);
		close_out;
	end
endmodule : swd_core_test
